// file: hw/msr_pkg.sv
package msr_pkg;
	// host register indices, one 32-bit word each
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_WADDR = 4'h2;
	localparam logic [3:0] REG_WDATA = 4'h3;
	localparam logic [3:0] REG_RADDR = 4'h4;
	localparam logic [3:0] REG_RDATA_LO = 4'h5;
	localparam logic [3:0] REG_RDATA_HI = 4'h6;
	// control bit positions (write one to start)
	localparam int CTRL_WRITE_BIT = 0;
	localparam int CTRL_READ_BIT = 1;
	localparam int CTRL_CLEAR_BIT = 2;
	// status bit positions
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_VALID_BIT = 1;
	// geometry of the ram: 2Kx9 writes, 512x36 reads
	localparam int WR_ADDR_W = 11;
	localparam int RD_ADDR_W = 9;
	localparam int WR_DATA_W = 9;
	localparam int HALF_W = 18;
	localparam int WORD_W = 36;
	localparam int PIN_ADDR_W = 14;
	localparam int BANK_W = 3;
	localparam logic [2:0] WR_ADDR_FILL = 3'h7;
	localparam logic [4:0] RD_ADDR_FILL = 5'h1f;
	localparam logic [2:0] BANK_NONE = 3'h0;
	// reset values of host registers
	localparam logic [10:0] WADDR_RST = 11'h000;
	localparam logic [8:0] WDATA_RST = 9'h000;
	localparam logic [8:0] RADDR_RST = 9'h000;
	localparam logic [35:0] RDATA_RST = 36'h000000000;
	// ram clock timing: sys_clk is 10 MHz
	localparam int SYS_CLK_HZ = 10000000;
	localparam int RAM_CLK_HZ = 5000000;
	localparam int RAM_HALF_CYC = SYS_CLK_HZ / (2 * RAM_CLK_HZ);
	// expected ram setup: one writer one reader, plain write behaviour,
	// output register on both sides, every other setting left default
	localparam int CFG_WR_WIDTH = 9;
	localparam int CFG_RD_WIDTH = 36;
	localparam bit CFG_OUTREG_ON = 1'b1;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WRITE = 3'b001,
		ST_RADDR = 3'b011,
		ST_ROREG = 3'b010,
		ST_RWAIT = 3'b110,
		ST_CLEAR = 3'b100
	} msr_state_type;

	typedef struct packed {
		logic [13:0] address_bus;
		logic address_freeze;
		logic [2:0] bank_select;
		logic [17:0] data_in;
		logic write_enable;
		logic clock_enable;
		logic outreg_enable;
		logic outreg_clear;
	} msr_pins_type;
endpackage : msr_pkg

// file: hw/msr_clk_div.sv
`timescale 1ns/1ns
module msr_clk_div (
	input wire logic sys_clk,
	input wire logic rst,
	output logic ram_clk,
	output logic fall_en
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic clk_q;
	logic last_w;

	assign last_w = (cnt_q == 8'(msr_pkg::RAM_HALF_CYC - 1));
	assign cnt_d = last_w ? 8'h00 : cnt_q + 8'h01;
	// pulse on the edge where the ram clock drops
	assign fall_en = last_w & clk_q;
	assign ram_clk = clk_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_q <= 8'h00;
			clk_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			if (last_w) begin
				clk_q <= ~clk_q;
			end
		end
	end
endmodule : msr_clk_div

// file: hw/msr_sync.sv
`timescale 1ns/1ns
module msr_sync #(
	parameter int WIDTH = 36
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_q;
			logic stab_q;
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					meta_q <= 1'b0;
					stab_q <= 1'b0;
				end else begin
					meta_q <= async_in[i];
					stab_q <= meta_q;
				end
			end
			assign sync_out[i] = stab_q;
		end
	endgenerate
endmodule : msr_sync

// file: hw/msr_host.sv
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module msr_host (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic write_side_clock,
	output logic read_side_clock,
	output msr_pkg::msr_pins_type write_side_pins,
	output msr_pkg::msr_pins_type read_side_pins,
	input wire logic [17:0] low_half_read_out,
	input wire logic [17:0] high_half_read_out
);
	msr_pkg::msr_state_type state_q;
	msr_pkg::msr_state_type state_d;
	msr_pkg::msr_pins_type wr_pins_q;
	msr_pkg::msr_pins_type wr_pins_d;
	msr_pkg::msr_pins_type rd_pins_q;
	msr_pkg::msr_pins_type rd_pins_d;
	logic [10:0] waddr_q;
	logic [8:0] wdata_q;
	logic [8:0] raddr_q;
	logic [35:0] rword_q;
	logic valid_q;
	logic go_write_q;
	logic go_read_q;
	logic go_clear_q;
	logic [31:0] reg_rdata_q;
	logic [31:0] rd_mux;
	logic ram_clk;
	logic fall_en;
	logic [35:0] word_sync;
	logic [35:0] word_raw;
	logic busy;
	logic sel_ctrl;
	logic wr_ctrl;
	logic wr_waddr;
	logic wr_wdata;
	logic wr_raddr;
	logic rd_hi;
	logic capture;
	logic pending;
	logic idle_now;
	logic take_cmd;
	logic sel_waddr;
	logic sel_wdata;
	logic sel_raddr;
	logic sel_rdata_hi;
	logic [31:0] status_word;
	logic [31:0] waddr_word;
	logic [31:0] wdata_word;
	logic [31:0] raddr_word;
	logic [31:0] rlo_word;
	logic [31:0] rhi_word;
	logic [13:0] wr_addr_pins;
	logic [13:0] rd_addr_pins;
	logic [17:0] wr_data_pins;

	msr_clk_div u_div (
		.sys_clk(sys_clk),
		.rst(rst),
		.ram_clk(ram_clk),
		.fall_en(fall_en)
	);

	assign word_raw = {high_half_read_out, low_half_read_out};

	msr_sync #(
		.WIDTH(msr_pkg::WORD_W)
	) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(word_raw),
		.sync_out(word_sync)
	);

	assign write_side_clock = ram_clk;
	assign read_side_clock = ram_clk;
	assign write_side_pins = wr_pins_q;
	assign read_side_pins = rd_pins_q;

	// queued command counts as busy until the sequencer has run it
	assign pending = go_write_q | go_read_q | go_clear_q;
	assign idle_now = (state_q == msr_pkg::ST_IDLE);
	assign busy = ~idle_now | pending;
	assign take_cmd = fall_en & idle_now;

	// register decode
	assign sel_ctrl = (reg_addr == msr_pkg::REG_CTRL);
	assign sel_waddr = (reg_addr == msr_pkg::REG_WADDR);
	assign sel_wdata = (reg_addr == msr_pkg::REG_WDATA);
	assign sel_raddr = (reg_addr == msr_pkg::REG_RADDR);
	assign sel_rdata_hi = (reg_addr == msr_pkg::REG_RDATA_HI);
	assign wr_ctrl = reg_wr & sel_ctrl & ~busy;
	assign wr_waddr = reg_wr & sel_waddr & ~busy;
	assign wr_wdata = reg_wr & sel_wdata & ~busy;
	assign wr_raddr = reg_wr & sel_raddr & ~busy;
	assign rd_hi = reg_rd & sel_rdata_hi;

	// read-back words, zero above each field
	always_comb begin
		status_word = 32'h00000000;
		status_word[msr_pkg::STAT_BUSY_BIT] = busy;
		status_word[msr_pkg::STAT_VALID_BIT] = valid_q;
	end
	assign waddr_word = {21'h000000, waddr_q};
	assign wdata_word = {23'h000000, wdata_q};
	assign raddr_word = {23'h000000, raddr_q};
	assign rlo_word = {14'h0000, rword_q[17:0]};
	assign rhi_word = {14'h0000, rword_q[35:18]};

	// write address with filled low bits
	assign wr_addr_pins = {waddr_q, msr_pkg::WR_ADDR_FILL};
	// read address with filled low bits
	assign rd_addr_pins = {raddr_q, msr_pkg::RD_ADDR_FILL};
	// write data in low bits, rest zero
	assign wr_data_pins = {9'h000, wdata_q};
	// output register loaded, word settled in sync
	assign capture = fall_en & (state_q == msr_pkg::ST_RWAIT);

	always_comb begin
		rd_mux = 32'h00000000;
		case (reg_addr)
			msr_pkg::REG_STATUS: begin
				rd_mux = status_word;
			end
			msr_pkg::REG_WADDR: begin
				rd_mux = waddr_word;
			end
			msr_pkg::REG_WDATA: begin
				rd_mux = wdata_word;
			end
			msr_pkg::REG_RADDR: begin
				rd_mux = raddr_word;
			end
			msr_pkg::REG_RDATA_LO: begin
				rd_mux = rlo_word;
			end
			msr_pkg::REG_RDATA_HI: begin
				rd_mux = rhi_word;
			end
			default: begin
				rd_mux = 32'h00000000;
			end
		endcase
	end
	assign reg_rdata = reg_rdata_q;

	// sequencer: steps once per ram clock, on its falling edge
	always_comb begin
		state_d = state_q;
		case (state_q)
			msr_pkg::ST_IDLE: begin
				if (go_clear_q) begin
					state_d = msr_pkg::ST_CLEAR;
				end else if (go_write_q) begin
					state_d = msr_pkg::ST_WRITE;
				end else if (go_read_q) begin
					state_d = msr_pkg::ST_RADDR;
				end
			end
			msr_pkg::ST_WRITE: begin
				state_d = msr_pkg::ST_IDLE;
			end
			msr_pkg::ST_RADDR: begin
				state_d = msr_pkg::ST_ROREG;
			end
			msr_pkg::ST_ROREG: begin
				state_d = msr_pkg::ST_RWAIT;
			end
			msr_pkg::ST_RWAIT: begin
				state_d = msr_pkg::ST_IDLE;
			end
			msr_pkg::ST_CLEAR: begin
				state_d = msr_pkg::ST_IDLE;
			end
			default: begin
				state_d = msr_pkg::ST_IDLE;
			end
		endcase
	end

	// pin values for the coming ram cycle
	always_comb begin
		wr_pins_d = '0;
		rd_pins_d = '0;
		wr_pins_d.address_bus = wr_addr_pins;
		rd_pins_d.address_bus = rd_addr_pins;
		wr_pins_d.address_freeze = 1'b0;
		rd_pins_d.address_freeze = 1'b0;
		wr_pins_d.bank_select = msr_pkg::BANK_NONE;
		rd_pins_d.bank_select = msr_pkg::BANK_NONE;
		wr_pins_d.data_in = wr_data_pins;
		rd_pins_d.data_in = 18'h00000;
		rd_pins_d.write_enable = 1'b0;
		case (state_d)
			msr_pkg::ST_WRITE: begin
				wr_pins_d.write_enable = 1'b1;
				wr_pins_d.clock_enable = 1'b1;
			end
			msr_pkg::ST_RADDR: begin
				rd_pins_d.clock_enable = 1'b1;
			end
			msr_pkg::ST_ROREG: begin
				rd_pins_d.outreg_enable = 1'b1;
				wr_pins_d.outreg_enable = 1'b1;
			end
			msr_pkg::ST_CLEAR: begin
				// each side cleared by its own pin
				wr_pins_d.outreg_clear = 1'b1;
				rd_pins_d.outreg_clear = 1'b1;
			end
			default: begin
				wr_pins_d.write_enable = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= msr_pkg::ST_IDLE;
		end else if (fall_en) begin
			state_q <= state_d;
		end
	end

	// pins move as the ram clock falls, half a ram cycle before sampling
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_pins_q <= '0;
			rd_pins_q <= '0;
		end else if (fall_en) begin
			wr_pins_q <= wr_pins_d;
			rd_pins_q <= rd_pins_d;
		end
	end

	// pending commands, taken by the sequencer when it leaves idle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			go_write_q <= 1'b0;
			go_read_q <= 1'b0;
			go_clear_q <= 1'b0;
		end else if (wr_ctrl) begin
			go_write_q <= reg_wdata[msr_pkg::CTRL_WRITE_BIT];
			go_read_q <= reg_wdata[msr_pkg::CTRL_READ_BIT];
			go_clear_q <= reg_wdata[msr_pkg::CTRL_CLEAR_BIT];
		end else if (take_cmd) begin
			go_write_q <= 1'b0;
			go_read_q <= go_read_q & (go_write_q | go_clear_q);
			go_clear_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			waddr_q <= msr_pkg::WADDR_RST;
			wdata_q <= msr_pkg::WDATA_RST;
			raddr_q <= msr_pkg::RADDR_RST;
		end else begin
			if (wr_waddr && !busy) begin
				waddr_q <= reg_wdata[10:0];
			end
			if (wr_wdata && !busy) begin
				wdata_q <= reg_wdata[8:0];
			end
			if (wr_raddr && !busy) begin
				raddr_q <= reg_wdata[8:0];
			end
		end
	end

	// captured word and its sticky valid flag; capture beats clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rword_q <= msr_pkg::RDATA_RST;
			valid_q <= 1'b0;
		end else begin
			if (capture) begin
				rword_q <= word_sync;
			end
			valid_q <= capture | (valid_q & ~rd_hi);
		end
	end

	// read data stand for the one cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata_q <= 32'h00000000;
		end else begin
			reg_rdata_q <= reg_rd ? rd_mux : 32'h00000000;
		end
	end
	// no ram setting is driven from here
	// pins not in the pin groups are not driven
	// host assumes 9-wide write, 36-wide read, outregs on
	// host assumes plain write behaviour on both sides
endmodule : msr_host

// file: dv/msr_ram_model.sv
`timescale 1ns/1ns
module msr_ram_model (
	input wire logic wclk,
	input wire logic rclk,
	input wire msr_pkg::msr_pins_type wp,
	input wire msr_pkg::msr_pins_type rp,
	output logic [17:0] lo,
	output logic [17:0] hi
);
	logic [8:0] mem_q [2048];
	logic [35:0] arr_q;
	logic [10:0] b;
	assign b = {rp.address_bus[13:5], 2'h0};
	always @(posedge wclk)
		if (wp.write_enable && wp.clock_enable)
			mem_q[wp.address_bus[13:3]] <= wp.data_in[8:0];
	always @(posedge rclk) begin
		if (rp.clock_enable)
			arr_q <= {mem_q[b+3], mem_q[b+2], mem_q[b+1], mem_q[b]};
		if (rp.outreg_clear)
			hi <= 18'h0;
		else if (rp.outreg_enable)
			hi <= arr_q[35:18];
	end
	// low half on the write side register
	always @(posedge wclk)
		if (wp.outreg_clear)
			lo <= 18'h0;
		else if (wp.outreg_enable)
			lo <= arr_q[17:0];
endmodule : msr_ram_model

// file: dv/msr_host_props.sv
`timescale 1ns/1ns
module msr_host_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic write_side_clock,
	input wire logic read_side_clock,
	input wire msr_pkg::msr_pins_type write_side_pins,
	input wire msr_pkg::msr_pins_type read_side_pins
);
	msr_pkg::msr_pins_type w, r;
	assign w = write_side_pins;
	assign r = read_side_pins;
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_access;
		(r.clock_enable && !r.outreg_enable) [*2];
	endsequence
	sequence s_load;
		(w.outreg_enable && r.outreg_enable && !r.clock_enable) [*2];
	endsequence
	a_read_steps: assert property (
		$rose(r.clock_enable) |-> s_access ##1 s_load) else $error("read");
	a_waddr_fill: assert property (
		w.write_enable |-> w.address_bus[2:0] == 3'h7) else $error("wfill");
	a_raddr_fill: assert property (
		r.clock_enable |-> r.address_bus[4:0] == 5'h1f) else $error("rfill");
	a_freeze_low: assert property (
		!(w.address_freeze || r.address_freeze)) else $error("freeze");
	a_bank_zero: assert property (
		(w.bank_select | r.bank_select) == 3'h0) else $error("bank");
	a_rd_side_idle: assert property (
		!r.write_enable && r.data_in == 18'h0) else $error("rside");
	a_write_pulse: assert property (
		$rose(w.write_enable) |-> (w.write_enable && w.clock_enable) [*2]
		##1 !w.write_enable) else $error("wpulse");
	a_no_mix: assert property (
		!(w.write_enable && r.clock_enable)) else $error("mix");
	a_clocks_same: assert property (
		write_side_clock == read_side_clock) else $error("clocks");
	a_pins_fall: assert property (
		$changed(w) || $changed(r) |-> $fell(write_side_clock))
		else $error("edge");
	a_clear_both: assert property (
		$rose(w.outreg_clear) |-> r.outreg_clear [*2]) else $error("clr");
endmodule : msr_host_props
bind msr_host msr_host_props u_props (
	.sys_clk(sys_clk),
	.rst(rst),
	.write_side_clock(write_side_clock),
	.read_side_clock(read_side_clock),
	.write_side_pins(write_side_pins),
	.read_side_pins(read_side_pins)
);

// file: dv/msr_host_tb.sv
`timescale 1ns/1ns
module msr_host_tb;
	typedef struct {logic [8:0] a; logic [35:0] d;} msr_row_type;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, v;
	logic wclk, rclk;
	logic [17:0] lo, hi;
	logic [35:0] word;
	msr_pkg::msr_pins_type wp, rp;
	int bad_count = 0;
	int checks_done = 0;
	msr_row_type rows [3] = '{'{9'h000, 36'h123456789},
		'{9'h1ff, 36'hfedcba987}, '{9'h0aa, 36'h5a5a5a5a5}};
	always #50 sys_clk = ~sys_clk;
	msr_host uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .write_side_clock(wclk),
		.read_side_clock(rclk), .write_side_pins(wp), .read_side_pins(rp),
		.low_half_read_out(lo), .high_half_read_out(hi));
	msr_ram_model u_ram (.wclk(wclk), .rclk(rclk), .wp(wp), .rp(rp),
		.lo(lo), .hi(hi));
	task automatic chk(input logic [35:0] s, input logic [35:0] e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#50 v = reg_rdata;
	endtask : rd
	task automatic idle();
		int n = 0;
		do begin
			rd(4'h1);
			n++;
		end while (v[0] !== 1'b0 && n < 30);
		chk(v[0], 1'b0);
	endtask : idle
	task automatic put(input logic [10:0] a, input logic [8:0] d);
		wr(4'h2, a);
		wr(4'h3, d);
		wr(4'h0, 32'h1);
		idle();
	endtask : put
	task automatic get(input logic [8:0] a, input logic [31:0] c);
		wr(4'h4, a);
		wr(4'h0, c);
		idle();
		chk(v[1], 1'b1);
		rd(4'h5);
		word[17:0] = v[17:0];
		rd(4'h6);
		word[35:18] = v[17:0];
		rd(4'h1);
		chk(v[1], 1'b0);
	endtask : get
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	initial begin
		#1000000;
		bad_count++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			for (int k = 0; k < 4; k++)
				put({rows[i].a, k[1:0]}, rows[i].d[9*k +: 9]);
			get(rows[i].a, 32'h2);
			chk(word, rows[i].d);
			$display("row %0d done", i);
		end
		// new byte then read in one command
		wr(4'h2, 11'h7fc);
		wr(4'h3, 9'h0f0);
		get(9'h1ff, 32'h3);
		chk(word, 36'hfedcba8f0);
		$display("combined done");
		wr(4'h0, 32'h4);
		idle();
		chk({hi, lo}, 36'h0);
		$display("clear done");
		wr(4'h2, 11'h010);
		wr(4'h3, 9'h0aa);
		wr(4'h0, 32'h1);
		wr(4'h3, 9'h155);
		idle();
		rd(4'h3);
		chk(v, 32'h0aa);
		get(9'h004, 32'h2);
		chk(word[8:0], 9'h0aa);
		$display("busy done");
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		rd(4'h1);
		chk(v, 32'h0);
		rd(4'h5);
		chk(v, 32'h0);
		rd(4'h7);
		chk(v, 32'h0);
		$display("reset done");
		close_out();
	end
endmodule : msr_host_tb
